//--- design/blps_pkg.sv
// Package for the boot loader and PLL strap sequencer: constants, layouts, types
// Behaviour
// - Strap pattern 00 selects ratio 40, 11 ratio 16, 10 ratio 8, 01 ratio 4.
// - Strap load sets output divider 1, reference divider 0, feedback 159/63/31/15.
// - Tile clock is oscillator times (feedback+1)/2 over (ref+1) and (output div+1).
// - Software may rewrite output divider, feedback and reference divider after boot.
// - While reset is low the device stays reset with GPIO pull-downs enabled.
// - After release an internal reset runs; boot starts 15 to 150 us later.
// - Without OTP selection the image comes from the embedded quad-SPI flash.
// - Security bit 5 set boots from OTP, clear boots from internal flash.
// - Image is size word, size times four program bytes, then a check word.
// - Check word 0x0D15AB1E skips CRC verification.
// - Size and check words arrive least significant byte first.
// - Program goes to lowest RAM address and runs from there when loaded.
// - Reflected CRC-32, poly 0xEDB88320, seed all ones, over size and program, inverted.
// - Security register loads from OTP before the boot source is chosen.
// - Secure boot bypasses boot ROM, fetching from OTP address 0.
package blps_pkg;

   // ==========================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int RST_WAIT_NS = 15000;
   localparam int RST_WAIT_CYC = (RST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Image format and CRC
   localparam logic [31:0] CRC_POLY = 32'hedb88320;
   localparam logic [31:0] CRC_SEED = 32'hffffffff;
   localparam logic [31:0] CRC_SKIP_MAGIC = 32'h0d15ab1e;
   localparam logic [31:0] RAM_WORDS = 32'h00008000;
   localparam int SEC_BOOT_BIT = 5;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] REG_PLL_CFG = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_SECURITY = 8'h08;
   localparam logic [7:0] REG_IMG_SIZE = 8'h0c;
   localparam logic [7:0] REG_CRC = 8'h10;
   localparam logic [7:0] REG_CLK_RATIO = 8'h14;

   // PLL_CFG fields
   localparam int PLL_FB_LSB = 0;
   localparam int PLL_REF_LSB = 12;
   localparam int PLL_OD_LSB = 18;
   // STATUS fields
   localparam int STS_STATE_LSB = 0;
   localparam int STS_OTP_BIT = 4;
   localparam int STS_RUN_BIT = 5;
   localparam int STS_ERR_BIT = 6;
   localparam int STS_STRAP_LSB = 8;
   // CLK_RATIO fields
   localparam int RATIO_NUM_LSB = 0;
   localparam int RATIO_DEN_LSB = 16;

   // ==========================================================
   // Strap table
   localparam logic [2:0] STRAP_OD = 3'h1;
   localparam logic [5:0] STRAP_REF = 6'h00;
   localparam logic [11:0] STRAP_FB_R40 = 12'h09f;
   localparam logic [11:0] STRAP_FB_R16 = 12'h03f;
   localparam logic [11:0] STRAP_FB_R8 = 12'h01f;
   localparam logic [11:0] STRAP_FB_R4 = 12'h00f;

   // ==========================================================
   // Types
   typedef struct packed {
      logic [2:0] output_divider;
      logic [11:0] feedback;
      logic [5:0] ref_divider;
   } blps_pll_t;

   typedef struct packed {
      logic we;
      logic [14:0] addr;
      logic [31:0] data;
   } blps_ram_wr_t;

   typedef enum logic [2:0] {
      ST_WAIT,
      ST_SEC,
      ST_SIZE,
      ST_PROG,
      ST_CHECK,
      ST_RUN,
      ST_ERR
   } blps_state_t;

endpackage : blps_pkg

//--- design/blps_loader.sv
// Boot sequencer: strap capture, internal reset wait, source select, image load and CRC check
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module blps_loader (
   input wire logic pclk,                      // 40 MHz reference clock
   input wire logic presetn,                   // Async reset, active low
   input wire logic clk_en,                    // Freezes all state when low
   input wire logic psel,                      // APB select
   input wire logic penable,                   // APB enable
   input wire logic pwrite,                    // APB direction
   input wire logic [7:0] paddr,               // APB byte address
   input wire logic [31:0] pwdata,             // APB write data
   output logic [31:0] prdata,                 // APB read data
   output logic pready,                        // APB ready
   output logic pslverr,                       // APB error, unmapped address
   input wire logic [1:0] mode_pin,            // Strap pins, asynchronous
   input wire logic sec_valid,                 // OTP security word valid
   input wire logic [31:0] sec_data,           // OTP security word
   output logic sec_req_q,                     // Request security word from OTP
   input wire logic src_valid,                 // Boot byte valid
   input wire logic [7:0] src_data,            // Boot byte
   output logic src_ready_q,                   // Boot byte accepted when valid
   output logic src_otp_q,                     // Source: 1 OTP, 0 flash
   output logic [23:0] src_addr_q,             // Byte address of next fetch
   output blps_pkg::blps_ram_wr_t ram_wr_q,    // RAM write port
   output blps_pkg::blps_pll_t pll_cfg_q,      // PLL settings
   output logic gpio_pd_en_q,                  // GPIO pull-down enable
   output logic run_q,                         // Start execution at address 0
   output logic boot_err_q                     // Image rejected
);
   import blps_pkg::*;

   // ==========================================================
   // Helpers
   function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] b);
      logic [31:0] c;
      c = crc ^ {24'h000000, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction : crc_byte

   function automatic blps_pll_t strap_pll(input logic [1:0] mode);
      blps_pll_t p;
      p.output_divider = STRAP_OD;
      p.ref_divider = STRAP_REF;
      case (mode)
         2'b00: p.feedback = STRAP_FB_R40;
         2'b11: p.feedback = STRAP_FB_R16;
         2'b10: p.feedback = STRAP_FB_R8;
         default: p.feedback = STRAP_FB_R4;
      endcase
      return p;
   endfunction : strap_pll

   default clocking dcb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ==========================================================
   // Strap synchroniser
   // No reset so the pins are already settled when reset releases
   logic [1:0] mode_s1_q;
   logic [1:0] mode_s2_q;
   logic strap_done_q;

   always_ff @(posedge pclk) begin
      if (clk_en) begin
         mode_s1_q <= mode_pin;
         mode_s2_q <= mode_s1_q;
      end
   end

   // ==========================================================
   // Sequencer state
   blps_state_t state_q;
   blps_state_t state_d;
   logic [9:0] wait_cnt_q;
   logic [31:0] sec_q;
   logic [31:0] word_q;
   logic [1:0] byte_cnt_q;
   logic [31:0] size_q;
   logic [31:0] words_left_q;
   logic [31:0] crc_q;
   logic [14:0] widx_q;
   logic take;
   logic last_byte;
   logic [31:0] asm_word;

   assign take = src_valid && src_ready_q;
   assign last_byte = (byte_cnt_q == 2'd3);
   assign asm_word = {src_data, word_q[31:8]};

   sequence s_word_done;
      clk_en && take && last_byte;
   endsequence

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_WAIT: begin
            if (wait_cnt_q == 10'(RST_WAIT_CYC - 1)) state_d = ST_SEC;
         end
         ST_SEC: begin
            if (sec_valid) state_d = ST_SIZE;
         end
         ST_SIZE: begin
            if (take && last_byte) begin
               if (asm_word == 32'h0) state_d = ST_CHECK;
               else if (asm_word > RAM_WORDS) state_d = ST_ERR;
               else state_d = ST_PROG;
            end
         end
         ST_PROG: begin
            if (take && last_byte && words_left_q == 32'h1) state_d = ST_CHECK;
         end
         ST_CHECK: begin
            if (take && last_byte) begin
               if (asm_word == CRC_SKIP_MAGIC) state_d = ST_RUN;
               else if (asm_word == ~crc_q) state_d = ST_RUN;
               else state_d = ST_ERR;
            end
         end
         ST_RUN: state_d = ST_RUN;
         ST_ERR: state_d = ST_ERR;
         default: state_d = ST_ERR;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_WAIT;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   // ==========================================================
   // Internal reset period
   // Lower bound of the window is used so boot is never late
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt_q <= 10'h000;
      end else if (clk_en && state_q == ST_WAIT && wait_cnt_q != 10'(RST_WAIT_CYC - 1)) begin
         wait_cnt_q <= wait_cnt_q + 10'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gpio_pd_en_q <= 1'b1;
      end else if (clk_en && state_q != ST_WAIT) begin
         gpio_pd_en_q <= 1'b0;
      end
   end

   wait_len_a: assert property ((state_q != ST_WAIT) |-> wait_cnt_q == 10'(RST_WAIT_CYC - 1))
      else $error("boot left internal reset early");
   pd_hold_a: assert property ((state_q == ST_WAIT) |-> gpio_pd_en_q)
      else $error("pull-downs off during reset");

   // ==========================================================
   // Security word and source select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_q <= 32'h0;
         sec_req_q <= 1'b0;
         src_otp_q <= 1'b0;
      end else if (clk_en) begin
         sec_req_q <= (state_d == ST_SEC);
         if (state_q == ST_SEC && sec_valid) begin
            sec_q <= sec_data;
            src_otp_q <= sec_data[SEC_BOOT_BIT];
         end
      end
   end

   src_sel_a: assert property ((state_q == ST_SIZE) |-> src_otp_q == sec_q[SEC_BOOT_BIT])
      else $error("boot source does not follow security bit");
   sec_first_a: assert property ((state_q == ST_SEC) |-> !src_ready_q)
      else $error("fetch before security word loaded");

   // ==========================================================
   // Byte stream, assembly and CRC
   // Fetch starts at byte 0 of either source, so OTP boot skips any ROM offset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_ready_q <= 1'b0;
         src_addr_q <= 24'h000000;
         word_q <= 32'h0;
         byte_cnt_q <= 2'd0;
         crc_q <= CRC_SEED;
      end else if (clk_en) begin
         src_ready_q <= (state_d == ST_SIZE) || (state_d == ST_PROG) || (state_d == ST_CHECK);
         if (state_q == ST_SEC) begin
            src_addr_q <= 24'h000000;
            crc_q <= CRC_SEED;
            byte_cnt_q <= 2'd0;
         end else if (take) begin
            src_addr_q <= src_addr_q + 24'h000001;
            word_q <= asm_word;
            byte_cnt_q <= byte_cnt_q + 2'd1;
            if (state_q != ST_CHECK) begin
               crc_q <= crc_byte(crc_q, src_data);
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         size_q <= 32'h0;
         words_left_q <= 32'h0;
      end else if (clk_en && take && last_byte) begin
         if (state_q == ST_SIZE) begin
            size_q <= asm_word;
            words_left_q <= asm_word;
         end else if (state_q == ST_PROG) begin
            words_left_q <= words_left_q - 32'h1;
         end
      end
   end

   // ==========================================================
   // RAM write port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ram_wr_q <= '0;
         widx_q <= 15'h0000;
      end else if (clk_en) begin
         ram_wr_q.we <= 1'b0;
         if (state_q == ST_SEC) begin
            widx_q <= 15'h0000;
         end else if (state_q == ST_PROG && take && last_byte) begin
            ram_wr_q.we <= 1'b1;
            ram_wr_q.addr <= widx_q;
            ram_wr_q.data <= asm_word;
            widx_q <= widx_q + 15'h0001;
         end
      end
   end

   ram_base_a: assert property ((state_q == ST_PROG && widx_q == 15'h0000) ##0 s_word_done
      |=> ram_wr_q.we && ram_wr_q.addr == 15'h0000)
      else $error("first program word not at RAM base");

   // ==========================================================
   // Run and error outcome
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 1'b0;
         boot_err_q <= 1'b0;
      end else if (clk_en) begin
         if (state_d == ST_RUN) run_q <= 1'b1;
         if (state_d == ST_ERR) boot_err_q <= 1'b1;
      end
   end

   magic_skip_a: assert property ((state_q == ST_CHECK) ##0 s_word_done ##0 (asm_word == CRC_SKIP_MAGIC)
      |=> run_q && !boot_err_q)
      else $error("magic word did not skip check");
   crc_good_a: assert property ((state_q == ST_CHECK) ##0 s_word_done ##0 (asm_word == ~crc_q)
      |=> run_q)
      else $error("matching CRC did not start program");
   crc_bad_a: assert property ((state_q == ST_CHECK) ##0 s_word_done
      ##0 (asm_word != ~crc_q && asm_word != CRC_SKIP_MAGIC) |=> boot_err_q && !run_q)
      else $error("CRC mismatch not reported");
   err_excl_a: assert property (boot_err_q |-> !run_q)
      else $error("program running after boot error");

   // ==========================================================
   // PLL settings: strap load, then software writes
   logic apb_wr;
   assign apb_wr = psel && penable && pready && pwrite && paddr == REG_PLL_CFG;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_done_q <= 1'b0;
         pll_cfg_q <= '0;
      end else if (clk_en) begin
         if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            pll_cfg_q <= strap_pll(mode_s2_q);
         end else if (apb_wr) begin
            pll_cfg_q.feedback <= pwdata[PLL_FB_LSB +: 12];
            pll_cfg_q.ref_divider <= pwdata[PLL_REF_LSB +: 6];
            pll_cfg_q.output_divider <= pwdata[PLL_OD_LSB +: 3];
         end
      end
   end

   strap_ratio_a: assert property ((clk_en && !strap_done_q && mode_s2_q == 2'b00)
      |=> pll_cfg_q.feedback == STRAP_FB_R40)
      else $error("strap 00 did not select ratio 40");
   strap_div_a: assert property ((clk_en && !strap_done_q)
      |=> pll_cfg_q.output_divider == STRAP_OD && pll_cfg_q.ref_divider == STRAP_REF)
      else $error("strap dividers wrong");
   pll_write_a: assert property ((clk_en && strap_done_q && apb_wr)
      |=> pll_cfg_q.feedback == $past(pwdata[11:0]))
      else $error("PLL write not applied");

   // ==========================================================
   // Clock ratio: tile = osc * num / (2 * den)
   logic [12:0] ratio_num;
   logic [9:0] ratio_den;
   assign ratio_num = 13'(pll_cfg_q.feedback) + 13'h0001;
   assign ratio_den = 10'((7'(pll_cfg_q.ref_divider) + 7'h01) * (4'(pll_cfg_q.output_divider) + 4'h1));

   // ==========================================================
   // APB slave: no wait states, read data captured in setup
   logic [31:0] rdata_d;
   logic addr_hit;

   always_comb begin
      rdata_d = 32'h0;
      addr_hit = 1'b1;
      case (paddr)
         REG_PLL_CFG: begin
            rdata_d[PLL_FB_LSB +: 12] = pll_cfg_q.feedback;
            rdata_d[PLL_REF_LSB +: 6] = pll_cfg_q.ref_divider;
            rdata_d[PLL_OD_LSB +: 3] = pll_cfg_q.output_divider;
         end
         REG_STATUS: begin
            rdata_d[STS_STATE_LSB +: 3] = state_q;
            rdata_d[STS_OTP_BIT] = src_otp_q;
            rdata_d[STS_RUN_BIT] = run_q;
            rdata_d[STS_ERR_BIT] = boot_err_q;
            rdata_d[STS_STRAP_LSB +: 2] = mode_s2_q;
         end
         REG_SECURITY: rdata_d = sec_q;
         REG_IMG_SIZE: rdata_d = size_q;
         REG_CRC: rdata_d = ~crc_q;
         REG_CLK_RATIO: begin
            rdata_d[RATIO_NUM_LSB +: 13] = ratio_num;
            rdata_d[RATIO_DEN_LSB +: 10] = ratio_den;
         end
         default: addr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         if (psel && !penable && !pready) begin
            pready <= 1'b1;
            prdata <= rdata_d;
            pslverr <= !addr_hit;
         end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   apb_ready_a: assert property ((clk_en && psel && !penable && !pready) |=> pready ##1 (!pready || !clk_en))
      else $error("APB ready not a single access cycle");

endmodule : blps_loader

//--- verification/blps_src_model.sv
// Far-side model: embedded boot flash or OTP byte stream plus security word
`timescale 1ns/1ps
module blps_src_model (
   input wire logic pclk,              // Reference clock
   input wire logic presetn,           // Async reset, active low
   input wire logic slow,              // Gap of one cycle after each byte
   input wire logic [31:0] sec_word,   // Stored security word
   input wire logic sec_req_q,         // Security word wanted
   output logic sec_valid,             // Security word valid
   output logic [31:0] sec_data,       // Security word
   input wire logic src_ready_q,       // Loader fetching
   input wire logic [23:0] src_addr_q, // Next byte address
   output logic src_valid,             // Byte valid
   output logic [7:0] src_data         // Byte
);
   logic [7:0] mem [0:63];
   // =====
   // Security word, answered one cycle after the request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sec_valid <= 1'b0;
      else
         sec_valid <= sec_req_q && !sec_valid;
   end
   // Idle lines show the inverse so a stale copy cannot pass
   assign sec_data = sec_valid ? sec_word : ~sec_word;
   // =====
   // Byte stream from address 0, held until taken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         src_valid <= 1'b0;
      else
         src_valid <= src_ready_q && !(slow && src_valid);
   end
   assign src_data = src_valid ? mem[src_addr_q[5:0]] : ~mem[src_addr_q[5:0]];
endmodule : blps_src_model

//--- verification/test_boot_loader_pll_strap.sv
// Self-checking bench for the boot loader and PLL strap sequencer
`timescale 1ns/1ps
module test_boot_loader_pll_strap;
   import blps_pkg::*;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, slow;
   logic [7:0] paddr, src_data;
   logic [31:0] pwdata, prdata, sec_data, sec_word;
   logic [1:0] mode_pin;
   logic sec_valid, sec_req_q, src_valid, src_ready_q, src_otp_q, gpio_pd_en_q, run_q, boot_err_q;
   logic [23:0] src_addr_q;
   blps_ram_wr_t ram_wr_q;
   blps_pll_t pll_cfg_q;
   logic [31:0] ram [0:15];
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int n_wr = 0;

   blps_loader blps_loader_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mode_pin(mode_pin), .sec_valid(sec_valid),
      .sec_data(sec_data), .sec_req_q(sec_req_q), .src_valid(src_valid), .src_data(src_data),
      .src_ready_q(src_ready_q), .src_otp_q(src_otp_q), .src_addr_q(src_addr_q), .ram_wr_q(ram_wr_q),
      .pll_cfg_q(pll_cfg_q), .gpio_pd_en_q(gpio_pd_en_q), .run_q(run_q), .boot_err_q(boot_err_q));
   blps_src_model src_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow), .sec_word(sec_word),
      .sec_req_q(sec_req_q), .sec_valid(sec_valid), .sec_data(sec_data), .src_ready_q(src_ready_q),
      .src_addr_q(src_addr_q), .src_valid(src_valid), .src_data(src_data));

   // =====
   // Clock, timeout and RAM port monitor
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 10000) begin
         n_errors++;
         end_sim();
      end
   end
   always @(posedge pclk) begin
      if (ram_wr_q.we === 1'b1) begin
         chk(ram_wr_q.addr, n_wr);
         ram[ram_wr_q.addr[3:0]] = ram_wr_q.data;
         n_wr++;
      end
   end

   // =====
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Supply taken as good long before; straps only change while reset is held
   task automatic do_reset(input logic [1:0] strap);
      @(posedge pclk);
      presetn <= 1'b0;
      mode_pin <= strap;
      repeat (2) @(posedge pclk);
      chk(gpio_pd_en_q, 32'h1);
      chk(run_q, 32'h0);
      presetn <= 1'b1;
   endtask : do_reset

   function automatic logic [31:0] wexp(input int j);
      return 32'h03020100 + j * 32'h04040404;
   endfunction : wexp

   function automatic logic [31:0] crc_upto(input int n);
      logic [31:0] c;
      c = 32'hffffffff;
      for (int i = 0; i < n; i++) begin
         c = c ^ {24'h0, src_model_inst.mem[i]};
         for (int k = 0; k < 8; k++)
            c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
      end
      return ~c;
   endfunction : crc_upto

   // Kind 0 good CRC, 1 skip word, 2 corrupted CRC
   task automatic boot(input logic [31:0] sec, input int nw, input int kind, input logic slw);
      int t;
      logic [31:0] cw;
      for (int j = 0; j < 16; j++)
         ram[j] = 32'h0;
      sec_word <= sec;
      slow <= slw;
      for (int k = 0; k < 4; k++)
         src_model_inst.mem[k] = 8'(nw >> (8 * k));
      for (int j = 0; j < nw; j++)
         for (int k = 0; k < 4; k++)
            src_model_inst.mem[4 + 4 * j + k] = 8'(wexp(j) >> (8 * k));
      cw = kind == 1 ? 32'h0d15ab1e : crc_upto(4 + 4 * nw) ^ {31'h0, kind == 2};
      for (int k = 0; k < 4; k++)
         src_model_inst.mem[4 + 4 * nw + k] = 8'(cw >> (8 * k));
      do_reset(2'b10);
      // Slow runs also freeze the block for 20 edges of the wait
      clk_en <= !slw;
      n_wr = 0;
      t = 0;
      while (sec_req_q !== 1'b1) begin
         @(posedge pclk);
         t++;
         if (t == 20) clk_en <= 1'b1;
      end
      chk(t >= 600 && t <= 6000, 32'h1);
      chk(t, RST_WAIT_CYC + 1 + (slw ? 20 : 0));
      while (run_q !== 1'b1 && boot_err_q !== 1'b1)
         @(posedge pclk);
      @(posedge pclk);
      chk(run_q, kind != 2);
      chk(boot_err_q, kind == 2);
      chk(src_otp_q, sec[5]);
      chk(src_addr_q, 8 + 4 * nw);
      chk(gpio_pd_en_q, 32'h0);
      if (kind != 2) begin
         chk(n_wr, nw);
         for (int j = 0; j < nw; j++)
            chk(ram[j], wexp(j));
      end
   endtask : boot

   // =====
   // Scenarios
   task automatic t_straps();
      logic [1:0] pat [4] = '{2'b00, 2'b11, 2'b10, 2'b01};
      logic [11:0] fb [4] = '{12'h09f, 12'h03f, 12'h01f, 12'h00f};
      logic [31:0] rd;
      logic er;
      for (int i = 0; i < 4; i++) begin
         do_reset(pat[i]);
         repeat (2) @(posedge pclk);
         chk(pll_cfg_q, {3'h1, fb[i], 6'h00});
         apb(1'b0, 8'h14, 32'h0, rd, er);
         chk(rd[12:0], fb[i] + 13'h1);
         chk(rd[25:16], 10'h002);
      end
   endtask : t_straps

   task automatic t_bad_crc();
      boot(32'h0, 1, 2, 1'b0);
      // Size word one beyond RAM is rejected before any program byte
      for (int k = 0; k < 4; k++)
         src_model_inst.mem[k] = 8'((RAM_WORDS + 32'h1) >> (8 * k));
      do_reset(2'b10);
      while (run_q !== 1'b1 && boot_err_q !== 1'b1)
         @(posedge pclk);
      @(posedge pclk);
      chk(boot_err_q, 32'h1);
      chk(run_q, 32'h0);
      chk(src_addr_q, 32'h4);
   endtask : t_bad_crc

   task automatic t_otp_skip();
      boot(32'h20, 2, 1, 1'b1);
   endtask : t_otp_skip

   task automatic t_zero_size();
      boot(32'h0, 0, 0, 1'b0);
   endtask : t_zero_size

   task automatic t_flash_crc();
      boot(32'hffffffdf, 3, 0, 1'b0);
   endtask : t_flash_crc

   task automatic t_regs();
      logic [31:0] rd;
      logic er;
      apb(1'b0, 8'h08, 32'h0, rd, er);
      chk(rd, 32'hffffffdf);
      apb(1'b1, 8'h04, 32'h0, rd, er);
      apb(1'b0, 8'h04, 32'h0, rd, er);
      chk(rd[9:0], 10'h225);
      apb(1'b1, 8'h00, 32'h00041063, rd, er);
      @(posedge pclk);
      chk(pll_cfg_q, {3'h1, 12'h063, 6'h01});
      apb(1'b0, 8'h00, 32'h0, rd, er);
      chk(rd, 32'h00041063);
      apb(1'b0, 8'h14, 32'h0, rd, er);
      chk(rd[25:0], {10'h004, 3'h0, 13'h064});
      apb(1'b0, 8'h20, 32'h0, rd, er);
      chk(er, 32'h1);
      chk(rd, 32'h0);
   endtask : t_regs

   initial begin
      presetn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      mode_pin = 2'b10;
      slow = 1'b0;
      sec_word = 32'h0;
      t_straps();
      t_bad_crc();
      t_otp_skip();
      t_zero_size();
      t_flash_crc();
      t_regs();
      end_sim();
   end
endmodule : test_boot_loader_pll_strap
